/* File: dv/panel_model.sv */
// Behavioural switch matrix, pot bank and comparator facing the panel scanner.
// Assumes the bench sets pot levels and switch closures through hierarchy.
`timescale 1ns/1ps
`include "fp_scan_consts.svh"
module panel_model
	import fp_scan_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic [`NUM_ROWS-1:0]   rowDrive_n,
	input  wire logic [`COL_SEL_W-1:0]  colSel,
	input  wire logic [`POT_SEL_W-1:0]  potSel,
	input  wire logic [`POT_GROUPS-1:0] potInhibit_n,
	input  wire logic [7:0]             dacLow,
	input  wire logic [`DAC_W-9:0]      dacHigh,
	output logic                        compIn,
	output logic                        colSense_n
);
	logic [`POT_W-1:0]  potLevel [24];
	logic [`NUM_SW-1:0] closed = '0;
	logic               flip = 1'b0;

	// An unrouted comparator input wanders from cycle to cycle.
	always @(posedge clk)
		flip <= !flip;

	always @*
	begin
		compIn = flip;
		for (int i = 0; i < 3; i++)
			if (potInhibit_n[i] == 1'b0)
				compIn = {potLevel[i*8+potSel], 4'h8} > {dacHigh, dacLow};
	end

	always @*
	begin
		colSense_n = 1'b1;
		for (int i = 0; i < 10; i++)
			if (!rowDrive_n[i] && colSel < 5 && closed[i*5+colSel])
				colSense_n = 1'b0;
	end
endmodule

/* File: dv/tb_top.sv */
// Self-checking bench for the panel scan and DAC control block.
// Assumes the panel model answers the comparator and column lines.
`timescale 1ns/1ps
`include "fp_scan_consts.svh"
module tb_top
	import fp_scan_pkg::*;
;
	localparam int TP = 2500;
	logic        clk;
	logic        rst_n = 1'b0;
	logic        tick = 1'b0;
	logic        refreshReq = 1'b0;
	logic        nvWrite = 1'b0;
	logic        compIn;
	logic        colSense_n;
	refresh_s    refreshIn = '0;
	refresh_s    e, rv;
	nv_s         nvIn = '0;
	logic [4:0]  potReadIdx = '0;
	logic [7:0]  dacLow;
	logic [7:0]  pLow = '0;
	logic [3:0]  dacHigh;
	logic [3:0]  pHigh = '0;
	logic        dacLowLoad, dacHighLoad, holdEnable, setupChange, refreshDone, checkMode;
	logic        pLoad = 1'b0;
	logic [2:0]  potSel, potInhibit_n, holdChan, colSel;
	logic [9:0]  rowDrive_n;
	logic [9:0]  pRow = 10'h3FF;
	logic [49:0] switchState;
	logic [49:0] exp;
	logic [7:0]  potReadVal;
	logic [7:0]  potV [24];
	logic [49:0] swQ [$];
	refresh_s    rfQ [$];
	logic        badDac = 1'b0, badRow = 1'b0, badInh = 1'b0, badCol = 1'b0;
	int          n_fail = 0, n_checks = 0, cyc = 0, scans = 0, lastScan = 0, prevScan = 0;
	int          nextRow = 0, w, r, s0;

	front_panel_scan_dac_control #(.NUM_POTS(24)) front_panel_scan_dac_control_inst (
		.clk(clk), .rst_n(rst_n), .tick(tick), .compIn(compIn), .colSense_n(colSense_n),
		.refreshReq(refreshReq), .refreshIn(refreshIn), .nvWrite(nvWrite), .nvIn(nvIn),
		.potReadIdx(potReadIdx), .dacLow(dacLow), .dacHigh(dacHigh),
		.dacLowLoad(dacLowLoad), .dacHighLoad(dacHighLoad), .potSel(potSel),
		.potInhibit_n(potInhibit_n), .holdChan(holdChan), .holdEnable(holdEnable),
		.rowDrive_n(rowDrive_n), .colSel(colSel), .setupChange(setupChange),
		.refreshDone(refreshDone), .switchState(switchState), .potReadVal(potReadVal),
		.checkMode(checkMode));

	panel_model panel_model_inst (.clk(clk), .rowDrive_n(rowDrive_n), .colSel(colSel),
		.potSel(potSel), .potInhibit_n(potInhibit_n), .dacLow(dacLow), .dacHigh(dacHigh),
		.compIn(compIn), .colSense_n(colSense_n));

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(string name, logic [63:0] seen, logic [63:0] want);
		n_checks++;
		if (seen !== want)
		begin
			n_fail++;
			$display("[ERR] %s expected %0h seen %0h", name, want, seen);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic nv(logic s, int a, int d);
		@(negedge clk);
		nvIn.isSwitch = s;
		nvIn.addr = 6'(a);
		nvIn.data = 8'(d);
		nvWrite = 1'b1;
		@(negedge clk);
		nvWrite = 1'b0;
	endtask

	task automatic rq(refresh_s a, refresh_s b);
		rfQ.push_back(b);
		// A request on the edge that starts the first job is a new job: set wins.
		if (a !== b)
			rfQ.push_back(b);
		@(negedge clk);
		refreshReq = 1'b1;
		refreshIn = a;
		if (a !== b)
		begin
			@(negedge clk);
			refreshIn = b;
		end
		@(negedge clk);
		refreshReq = 1'b0;
		repeat (8) @(negedge clk);
		check("holdEnable", holdEnable, 1);
		for (w = 0; w < 20000 && rfQ.size() != 0; w++)
			@(negedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial
	begin
		@(posedge rst_n);
		forever
		begin
			repeat (TP - 1) @(negedge clk);
			tick = 1'b1;
			@(negedge clk);
			tick = 1'b0;
		end
	end

	// Results are taken off the queues as they appear; port hygiene is watched each cycle.
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 95000)
		begin
			check("timeout", 1, 0);
			finish_test();
		end
		if (rst_n)
		begin
			if (setupChange)
				check("switchState", switchState, swQ.size() ? swQ.pop_front() : 50'h0);
			if (refreshDone)
			begin
				check("refreshDone", rfQ.size() != 0, 1);
				e = rfQ.size() ? rfQ.pop_front() : '0;
				check("holdChan", holdChan, e.chan);
				check("dacCode", {dacHigh, dacLow}, e.code);
				// The hold is already released when done is reported.
				check("holdEnable", holdEnable, 0);
			end
			if (dacHighLoad !== pLoad || (dacLow !== pLow && !dacLowLoad)
				|| (dacHigh !== pHigh && !dacHighLoad))
				badDac = 1'b1;
			if ($countones(~rowDrive_n) > 1)
				badRow = 1'b1;
			if (rowDrive_n !== pRow && rowDrive_n !== 10'h3FF)
			begin
				if (rowDrive_n !== ~(10'h001 << nextRow))
					badRow = 1'b1;
				nextRow = (nextRow + 1) % 10;
			end
			if (!rowDrive_n[0] && pRow[0])
			begin
				prevScan = lastScan;
				lastScan = cyc;
				scans++;
			end
			if ($countones(~potInhibit_n) > 1)
				badInh = 1'b1;
			if (colSel > 4)
				badCol = 1'b1;
		end
		pRow = rowDrive_n;
		pLow = dacLow;
		pHigh = dacHigh;
		pLoad = dacLowLoad;
	end

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		void'($urandom(32'h4BE01C01));
		for (int i = 0; i < 24; i++)
		begin
			potV[i] = 8'(8 + $urandom % 240);
			panel_model_inst.potLevel[i] = potV[i];
		end
		panel_model_inst.closed = 50'h80;
		repeat (6) @(negedge clk);
		check("potInhibit_n", potInhibit_n, 3'h7);
		check("rowDrive_n", rowDrive_n, 10'h3FF);
		check("potSel", potSel, 3'h0);
		check("checkMode", checkMode, 0);
		rst_n = 1'b1;
		$display("test reset done");

		for (int i = 0; i < 24; i++)
			nv(1'b0, i, potV[i] + (i == 5 ? 5 : (i == 9 ? -1 : 0)));
		nv(1'b1, 7, 1);
		repeat (2) @(negedge clk);
		check("switchState", switchState, 50'h80);
		check("checkMode", checkMode, 1);
		$display("test restore done");

		for (int ch = 0; ch < 8; ch++)
		begin
			rv = {3'(ch), 12'($urandom)};
			rq(rv, rv);
			repeat (2) @(negedge clk);
			check("holdEnable", holdEnable, 0);
		end
		rq({3'h7, 12'hA5A}, {3'h7, 12'h5A5});
		repeat (600) @(negedge clk);
		check("refreshQueue", rfQ.size(), 0);
		$display("test refresh done");

		swQ.push_back(50'h80);
		potReadIdx = 5'd5;
		for (w = 0; w < 40000 && potReadVal !== potV[5]; w++)
			@(negedge clk);
		for (int i = 0; i < 24; i++)
		begin
			potReadIdx = 5'(i);
			repeat (2) @(negedge clk);
			check("potReadVal", potReadVal, i == 9 ? potV[9] - 8'h01 : potV[i]);
		end
		check("potChange", swQ.size(), 0);
		$display("test pots done");

		r = 20 + $urandom % 30;
		exp = 50'h80;
		exp[7] = 1'b0;
		swQ.push_back(exp);
		exp[12] = 1'b1;
		swQ.push_back(exp);
		exp[r] = 1'b1;
		swQ.push_back(exp);
		panel_model_inst.closed = exp;
		for (w = 0; w < 40000 && swQ.size() != 0; w++)
			@(negedge clk);
		s0 = scans;
		for (int k = 0; k < 20; k++)
		begin
			panel_model_inst.closed[12] = !panel_model_inst.closed[12];
			repeat (10) @(negedge clk);
		end
		for (w = 0; w < 30000 && scans == s0; w++)
			@(negedge clk);
		repeat (5200) @(negedge clk);
		check("switchState", switchState, exp);
		check("scanPeriod", lastScan - prevScan, 10 * TP);
		$display("test switches done");

		check("dacLoad", badDac, 0);
		check("rowOrder", badRow, 0);
		check("potGroups", badInh, 0);
		check("colRange", badCol, 0);
		finish_test();
	end
endmodule

/* File: rtl/front_panel_scan_dac_control.sv */
// Front-panel pot digitiser, switch-matrix scanner and analog refresh sequencer.
// Assumes tick is a one-cycle pulse on clk; comparator and column lines are async pins.
`timescale 1ns/1ps
`include "fp_scan_consts.svh"
module front_panel_scan_dac_control
	import fp_scan_pkg::*;
#(
	parameter int NUM_POTS = 24
)
(
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire logic                   tick,
	input  wire logic                   compIn,
	input  wire logic                   colSense_n,
	input  wire logic                   refreshReq,
	input  wire refresh_s               refreshIn,
	input  wire logic                   nvWrite,
	input  wire nv_s                    nvIn,
	input  wire logic [`POT_IDX_W-1:0]  potReadIdx,
	output logic      [7:0]             dacLow,
	output logic      [`DAC_W-9:0]      dacHigh,
	output logic                        dacLowLoad,
	output logic                        dacHighLoad,
	output logic      [`POT_SEL_W-1:0]  potSel,
	output logic      [`POT_GROUPS-1:0] potInhibit_n,
	output logic      [`CHAN_W-1:0]     holdChan,
	output logic                        holdEnable,
	output logic      [`NUM_ROWS-1:0]   rowDrive_n,
	output logic      [`COL_SEL_W-1:0]  colSel,
	output logic                        setupChange,
	output logic                        refreshDone,
	output logic      [`NUM_SW-1:0]     switchState,
	output logic      [`POT_W-1:0]      potReadVal,
	output logic                        checkMode
);

////////////////////////////////////////////////////////////////////////////////
	state_e                  state;
	logic [1:0]              compSync;
	logic [1:0]              colSync;
	logic                    compS;
	logic                    colS;
	logic [3:0]              scanTickCnt;
	logic [3:0]              potTickCnt;
	logic                    swPending;
	logic                    potPending;
	logic                    rfPending;
	refresh_s                rfLatched;
	logic [`WAIT_W-1:0]      waitCnt;
	logic [`POT_IDX_W-1:0]   potIdx;
	logic [2:0]              bitIdx;
	logic [`POT_W-1:0]       sarVal;
	logic [3:0]              row;
	logic [`COL_SEL_W-1:0]   col;
	logic [`SW_IDX_W-1:0]    swIdx;
	logic [`POT_W-1:0]       potMem [NUM_POTS];
	logic [NUM_POTS-1:0]     potKnown;
	logic [`DAC_W-9:0]       pendHigh;
	logic                    dacWr;
	logic [`DAC_W-1:0]       dacVal;
	logic [`POT_W-1:0]       trialBits;
	logic [`POT_W:0]         hiSum;
	logic [`POT_W:0]         loDiff;
	logic [`POT_W-1:0]       sarFinal;
	logic                    potStore;
	logic                    potChg;
	logic                    swChg;
	logic                    lastPot;

	// Two flops on each async pin before any logic reads it.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			compSync <= 2'h0;
			colSync <= 2'h3;
		end
		else
		begin
			compSync <= {compSync[0], compIn};
			colSync <= {colSync[0], colSense_n};
		end
	end
	assign compS = compSync[1];
	assign colS = colSync[1];

////////////////////////////////////////////////////////////////////////////////
	// tenth tick for the switch scan, fifth tick for the pots
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			scanTickCnt <= 4'h0;
			potTickCnt <= 4'h0;
		end
		else if (tick)
		begin
			scanTickCnt <= (scanTickCnt == `SCAN_TICKS - 4'h1) ? 4'h0 : scanTickCnt + 4'h1;
			potTickCnt <= (potTickCnt == `POT_TICKS - 4'h1) ? 4'h0 : potTickCnt + 4'h1;
		end
	end

	// A request arriving as its job starts is kept: set wins over clear.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			swPending <= 1'b0;
			potPending <= 1'b0;
			rfPending <= 1'b0;
			rfLatched <= '0;
		end
		else
		begin
			swPending <= (tick && scanTickCnt == `SCAN_TICKS - 4'h1)
				|| (swPending && !(state == IDLE && !rfPending));
			potPending <= (tick && potTickCnt == `POT_TICKS - 4'h1)
				|| (potPending && !(state == IDLE && !rfPending && !swPending));
			rfPending <= refreshReq || (rfPending && state != IDLE);
			if (refreshReq)
				rfLatched <= refreshIn;
		end
	end

////////////////////////////////////////////////////////////////////////////////
	assign trialBits = sarVal | (8'h01 << bitIdx);
	assign hiSum = {1'b0, potMem[potIdx]} + {1'b0, `DRIFT};
	assign loDiff = {1'b0, potMem[potIdx]} - {1'b0, `DRIFT};
	assign sarFinal = compS ? trialBits : sarVal;
	assign potStore = state == SAR_DECIDE && bitIdx == 3'h0;
	assign lastPot = potIdx == `POT_IDX_W'(NUM_POTS - 1);

	always_comb
	begin
		dacWr = 1'b0;
		dacVal = `DAC_RST;
		unique case (state)
			RF_SET:
			begin
				dacWr = 1'b1;
				dacVal = rfLatched.code;
			end
			SAR_SET:
			begin
				dacWr = 1'b1;
				dacVal = {trialBits, 4'h0};
			end
			CHK_HI_SET:
			begin
				dacWr = 1'b1;
				dacVal = {(hiSum[`POT_W] ? 8'hFF : hiSum[`POT_W-1:0]), 4'h0};
			end
			CHK_LO_SET:
			begin
				dacWr = 1'b1;
				dacVal = {(loDiff[`POT_W] ? 8'h00 : loDiff[`POT_W-1:0]), 4'h0};
			end
			default:
			begin
				dacWr = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dacLow <= 8'h00;
			dacHigh <= 4'h0;
			dacLowLoad <= 1'b0;
			dacHighLoad <= 1'b0;
			pendHigh <= 4'h0;
		end
		else
		begin
			dacLowLoad <= dacWr;
			dacHighLoad <= dacLowLoad;
			if (dacWr)
			begin
				dacLow <= dacVal[7:0];
				pendHigh <= dacVal[`DAC_W-1:8];
			end
			if (dacLowLoad)
				dacHigh <= pendHigh;
		end
	end

////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= IDLE;
			waitCnt <= '0;
			potIdx <= '0;
			bitIdx <= 3'h7;
			sarVal <= 8'h00;
			row <= 4'h0;
			col <= '0;
			swIdx <= '0;
		end
		else
		begin
			if (waitCnt != '0)
				waitCnt <= waitCnt - `WAIT_W'(1);
			unique case (state)
				IDLE:
				begin
					potIdx <= '0;
					row <= 4'h0;
					col <= '0;
					swIdx <= '0;
					bitIdx <= 3'h7;
					sarVal <= 8'h00;
					if (rfPending)
						state <= RF_SET;
					else if (swPending)
						state <= SW_SET;
					else if (potPending)
						state <= checkMode ? CHK_HI_SET : SAR_SET;
				end
				RF_SET:
				begin
					waitCnt <= `WAIT_W'(`HOLD_CHARGE_CYC - 1);
					state <= RF_WAIT;
				end
				RF_WAIT:
				begin
					if (waitCnt == '0)
						state <= IDLE;
				end
				SAR_SET:
				begin
					waitCnt <= `WAIT_W'(`COMP_SETTLE_CYC - 1);
					state <= SAR_WAIT;
				end
				SAR_WAIT:
				begin
					if (waitCnt == '0)
						state <= SAR_DECIDE;
				end
				SAR_DECIDE:
				begin
					sarVal <= sarFinal;
					bitIdx <= bitIdx - 3'h1;
					state <= SAR_SET;
					if (bitIdx == 3'h0)
					begin
						sarVal <= 8'h00;
						potIdx <= potIdx + `POT_IDX_W'(1);
						state <= lastPot ? IDLE : (checkMode ? CHK_HI_SET : SAR_SET);
						if (lastPot)
							potIdx <= '0;
					end
				end
				CHK_HI_SET:
				begin
					waitCnt <= `WAIT_W'(`COMP_SETTLE_CYC - 1);
					state <= CHK_HI_WAIT;
				end
				CHK_HI_WAIT:
				begin
					if (waitCnt == '0)
						state <= (!compS || hiSum[`POT_W]) ? CHK_LO_SET : SAR_SET;
				end
				CHK_LO_SET:
				begin
					waitCnt <= `WAIT_W'(`COMP_SETTLE_CYC - 1);
					state <= CHK_LO_WAIT;
				end
				CHK_LO_WAIT:
				begin
					if (waitCnt == '0)
					begin
						if (compS || loDiff[`POT_W])
						begin
							potIdx <= lastPot ? '0 : potIdx + `POT_IDX_W'(1);
							state <= lastPot ? IDLE : CHK_HI_SET;
						end
						else
							state <= SAR_SET;
					end
				end
				SW_SET:
				begin
					waitCnt <= `WAIT_W'(`COL_SETTLE_CYC - 1);
					state <= SW_WAIT;
				end
				SW_WAIT:
				begin
					if (waitCnt == '0)
						state <= SW_READ;
				end
				SW_READ:
				begin
					swIdx <= swIdx + `SW_IDX_W'(1);
					col <= col + `COL_SEL_W'(1);
					state <= SW_SET;
					if (col == `COL_SEL_W'(`NUM_COLS - 1))
					begin
						col <= '0;
						row <= row + 4'h1;
						if (row == 4'(`NUM_ROWS - 1))
							state <= IDLE;
					end
				end
				default:
				begin
					state <= IDLE;
				end
			endcase
		end
	end

////////////////////////////////////////////////////////////////////////////////
	assign potChg = potStore && (!potKnown[potIdx] || sarFinal != potMem[potIdx]);
	assign swChg = state == SW_READ && !colS != switchState[swIdx];

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			potKnown <= '0;
			for (int i = 0; i < NUM_POTS; i++)
				potMem[i] <= 8'h00;
		end
		else if (potStore)
		begin
			potMem[potIdx] <= sarFinal;
			potKnown[potIdx] <= 1'b1;
		end
		else if (nvWrite && !nvIn.isSwitch && nvIn.addr < 6'(NUM_POTS))
		begin
			potMem[nvIn.addr[`POT_IDX_W-1:0]] <= nvIn.data;
			potKnown[nvIn.addr[`POT_IDX_W-1:0]] <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			switchState <= '0;
		else if (swChg)
			switchState[swIdx] <= !colS;
		else if (nvWrite && nvIn.isSwitch && nvIn.addr < 6'(`NUM_SW))
			switchState[nvIn.addr] <= nvIn.data[0];
	end

////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			potSel <= '0;
			potInhibit_n <= `INH_IDLE;
			holdChan <= '0;
			holdEnable <= 1'b0;
			rowDrive_n <= `ROW_IDLE;
			colSel <= '0;
			setupChange <= 1'b0;
			refreshDone <= 1'b0;
			potReadVal <= 8'h00;
			checkMode <= 1'b0;
		end
		else
		begin
			if (state == SAR_SET || state == CHK_HI_SET)
				potSel <= potIdx[`POT_SEL_W-1:0];
			potInhibit_n <= (state == IDLE || state inside {RF_SET, RF_WAIT, SW_SET, SW_WAIT,
				SW_READ}) ? `INH_IDLE : ~(3'h1 << potIdx[`POT_IDX_W-1:`POT_SEL_W]);
			if (state == RF_SET)
				holdChan <= rfLatched.chan;
			holdEnable <= state == RF_WAIT && waitCnt != '0;
			refreshDone <= state == RF_WAIT && waitCnt == '0;
			rowDrive_n <= (state inside {SW_SET, SW_WAIT, SW_READ})
				? ~(10'h001 << row) : `ROW_IDLE;
			colSel <= col;
			setupChange <= swChg || potChg;
			potReadVal <= potMem[potReadIdx];
			checkMode <= &potKnown;
		end
	end

////////////////////////////////////////////////////////////////////////////////
	// single group
	a_inhibit_onehot: assert property (@(posedge clk) disable iff (!rst_n)
		$countones(~potInhibit_n) <= 1)
		else $error("More than one pot selector group enabled.");
	a_byte_order: assert property (@(posedge clk) disable iff (!rst_n)
		dacLowLoad |=> dacHighLoad && dacHigh == $past(pendHigh))
		else $error("High byte load did not follow low byte load.");
	a_dac_low: assert property (@(posedge clk) disable iff (!rst_n)
		$past(dacWr) |-> dacLow == $past(dacVal[7:0]))
		else $error("DAC low byte does not match the written code.");
	a_row_single: assert property (@(posedge clk) disable iff (!rst_n)
		$countones(~rowDrive_n) <= 1)
		else $error("More than one switch row driven low.");
	a_col_range: assert property (@(posedge clk) disable iff (!rst_n)
		colSel < 3'h5)
		else $error("Column select out of range.");
	a_potsel_hold: assert property (@(posedge clk) disable iff (!rst_n)
		$changed(potSel) |-> $past(state) inside {SAR_SET, CHK_HI_SET})
		else $error("Pot select changed without a new selection.");
	a_hold_release: assert property (@(posedge clk) disable iff (!rst_n)
		refreshDone |-> $past(holdEnable) ##1 !holdEnable)
		else $error("Hold multiplexer not released after refresh.");
	a_switch_flag: assert property (@(posedge clk) disable iff (!rst_n)
		$changed(switchState) && !$past(nvWrite) |-> setupChange)
		else $error("Switch change stored without setup change flag.");
	a_scan_ticks: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(swPending) |-> $past(tick) && $past(scanTickCnt) == 4'h9)
		else $error("Switch scan started off the tenth tick.");
	a_settle_first: assert property (@(posedge clk) disable iff (!rst_n)
		state == SAR_DECIDE |-> $past(state) == SAR_WAIT && $past(waitCnt) == '0)
		else $error("Search decided before the comparator settled.");
endmodule

/* File: shared/fp_scan_consts.svh */
// Constants for the front-panel scan and DAC control block.
// Assumes a 100 MHz system clock and a periodic real-time tick pulse.
`ifndef FP_SCAN_CONSTS_SVH
`define FP_SCAN_CONSTS_SVH
`define DAC_W            12
`define POT_W            8
`define POT_SEL_W        3
`define POT_GROUPS       3
`define POT_IDX_W        5
`define NUM_ROWS         10
`define NUM_COLS         5
`define NUM_SW           50
`define SW_IDX_W         6
`define COL_SEL_W        3
`define CHAN_W           3
`define SCAN_TICKS       4'hA
`define POT_TICKS        4'h5
`define CLK_NS           10
`define COMP_SETTLE_NS   2000
`define COL_SETTLE_NS    1000
`define HOLD_CHARGE_NS   5000
`define COMP_SETTLE_CYC  ((`COMP_SETTLE_NS + `CLK_NS - 1) / `CLK_NS)
`define COL_SETTLE_CYC   ((`COL_SETTLE_NS + `CLK_NS - 1) / `CLK_NS)
`define HOLD_CHARGE_CYC  ((`HOLD_CHARGE_NS + `CLK_NS - 1) / `CLK_NS)
`define WAIT_W           10
`define DRIFT            8'h02
`define DAC_RST          12'h000
`define ROW_IDLE         10'h3FF
`define INH_IDLE         3'h7
`endif

/* File: shared/fp_scan_pkg.sv */
// Types shared by the front-panel scan and DAC control block.
// Assumes the constants header sits beside it on the include path.
`include "fp_scan_consts.svh"
package fp_scan_pkg;
	typedef enum logic [3:0]
	{
		IDLE        = 4'h0,
		RF_SET      = 4'h1,
		RF_WAIT     = 4'h3,
		SAR_SET     = 4'h2,
		SAR_WAIT    = 4'h6,
		SAR_DECIDE  = 4'h7,
		CHK_HI_SET  = 4'h5,
		CHK_HI_WAIT = 4'h4,
		CHK_LO_SET  = 4'hC,
		CHK_LO_WAIT = 4'hD,
		SW_SET      = 4'hF,
		SW_WAIT     = 4'hE,
		SW_READ     = 4'hA
	} state_e;

	typedef struct packed
	{
		logic [`CHAN_W-1:0] chan;
		logic [`DAC_W-1:0]  code;
	} refresh_s;

	typedef struct packed
	{
		logic                 isSwitch;
		logic [5:0]           addr;
		logic [`POT_W-1:0]    data;
	} nv_s;
endpackage
